//--- design/battery_alarm_irq_cfg.svh
// constants for the battery alarm comparators and dedicated interrupt pins
`ifndef BATTERY_ALARM_IRQ_CFG_SVH
`define BATTERY_ALARM_IRQ_CFG_SVH

`define OFS_IRQ_PIN_OUTPUT_CFG      7'h4C
`define OFS_COMPARATOR_POLARITY     7'h4E
`define OFS_IRQ_PIN_FUNCTION_CFG    7'h56
`define OFS_ALARM_DELAY_CONTROL     7'h58
`define OFS_COMPARATOR_SRC_REF      7'h5C

`define BIT_FIRST_POLARITY          15
`define BIT_SECOND_POLARITY         14
`define RST_POLARITY                1'h1

`define DELAY_MSB                   15
`define DELAY_LSB                   13
`define RST_DELAY                   3'h0
`define DELAY_EXP_BASE              12

`define BIT_FIRST_REF               14
`define FIRST_SRC_MSB               13
`define FIRST_SRC_LSB               12
`define BIT_SECOND_REF              11
`define SECOND_SRC_MSB              10
`define SECOND_SRC_LSB              9
`define RST_REF                     1'h0
`define RST_SRC                     2'h0

`define BIT_DATA_IRQ_CFG            4
`define BIT_PEN_IRQ_CFG             3
`define RST_PIN_CFG                 1'h1

`define BIT_FIRST_STATUS            15
`define BIT_SECOND_STATUS           14

`define FRAME_TIME_US               20.8
`define CLK_PERIOD_NS               100.0
`define FRAME_CYCLES                ($rtoi(`FRAME_TIME_US * 1000.0 / `CLK_PERIOD_NS))

`endif

//--- design/battery_alarm_pkg.sv
// types shared by the battery alarm control files
package battery_alarm_pkg;
	typedef enum logic {
		DLY_IDLE,
		DLY_COUNTING
	} delay_state_t;
	typedef logic [1:0]  source_sel_t;
	typedef logic [15:0] reg_word_t;
endpackage : battery_alarm_pkg

//--- design/frame_tick_divider.sv
// divider producing a one-cycle enable once per link frame
`timescale 1ns/1ps
module frame_tick_divider #(
	parameter int CYCLES = 208
) (
	input  wire logic clk,
	input  wire logic nrst,
	output logic      tick
);
	localparam int CW = $clog2(CYCLES);

	logic [CW-1:0] count_reg;
	wire           wrap = (count_reg == CW'(CYCLES - 1));

	always_ff @(posedge clk) begin
		if (!nrst) begin
			count_reg <= '0;
			tick      <= 1'b0;
		end else begin
			count_reg <= wrap ? '0 : count_reg + CW'(1);
			tick      <= wrap;
		end
	end
endmodule : frame_tick_divider

//--- design/comparator_channel.sv
// one comparator: power decode and polarity of the alarm
`timescale 1ns/1ps
module comparator_channel
	import battery_alarm_pkg::*;
(
	input  wire logic  polarity,
	input  wire logic  ref_select,
	input  wire source_sel_t source_select,
	input  wire logic  raw_above,
	output logic       powered,
	output logic       alarm
);
	// code 00 only stays on when the reference is the external pin
	assign powered = (source_select != 2'h0) | ref_select;
	// comparator reports input above reference; polarity picks the alarm side
	assign alarm   = powered & (polarity ? raw_above : ~raw_above);
endmodule : comparator_channel

//--- design/battery_alarm_irq_control.sv
// battery alarm comparator control, low-battery delay and dedicated irq pins
`timescale 1ns/1ps
`include "battery_alarm_irq_cfg.svh"
module battery_alarm_irq_control
	import battery_alarm_pkg::*;
#(
	parameter int FRAME_CYCLES   = `FRAME_CYCLES,
	parameter int DELAY_EXP_BASE = `DELAY_EXP_BASE,
	parameter int DELAY_CNT_W    = 20
) (
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [6:0]  REG_ADDR,
	input  wire reg_word_t   REG_WDATA,
	output reg_word_t        REG_RDATA,
	output logic             REG_RVALID,
	input  wire logic        DEAD_BATTERY_COMPARATOR,
	input  wire logic        LOW_BATTERY_COMPARATOR,
	input  wire logic        SLEEP,
	input  wire logic        LOW_BATTERY_IRQ_ENABLE,
	input  wire logic        AUX_DATA_READY,
	input  wire logic        PANEL_TOUCHED,
	output logic             FIRST_REFERENCE_SELECT,
	output source_sel_t      FIRST_SOURCE_SELECT,
	output logic             FIRST_POWER_DOWN,
	output logic             SECOND_REFERENCE_SELECT,
	output source_sel_t      SECOND_SOURCE_SELECT,
	output logic             SECOND_POWER_DOWN,
	output logic             DEAD_BATTERY_STATUS,
	output logic             LOW_BATTERY_STATUS_BIT,
	output logic             LOW_BATTERY_IRQ,
	output logic             DELAY_TIMER_BUSY,
	output logic             OSC_START,
	output logic             DATA_READY_IRQ_PIN,
	output logic             TOUCH_DETECT_IRQ_PIN
);
	// ---------------- register storage ----------------
	logic        first_alarm_polarity_reg;
	logic        second_alarm_polarity_reg;
	logic [2:0]  low_battery_delay_select_reg;
	logic        first_reference_select_reg;
	source_sel_t first_source_select_reg;
	logic        second_reference_select_reg;
	source_sel_t second_source_select_reg;
	logic        data_irq_output_config_reg;
	logic        pen_irq_output_config_reg;
	logic        data_irq_function_config_reg;
	logic        pen_irq_function_config_reg;

	// ---------------- address decode ----------------
	wire hit_output_cfg   = (REG_ADDR == `OFS_IRQ_PIN_OUTPUT_CFG);
	wire hit_polarity     = (REG_ADDR == `OFS_COMPARATOR_POLARITY);
	wire hit_function_cfg = (REG_ADDR == `OFS_IRQ_PIN_FUNCTION_CFG);
	wire hit_delay        = (REG_ADDR == `OFS_ALARM_DELAY_CONTROL);
	wire hit_src_ref      = (REG_ADDR == `OFS_COMPARATOR_SRC_REF);

	wire wr_output_cfg    = REG_WR & hit_output_cfg;
	wire wr_polarity      = REG_WR & hit_polarity;
	wire wr_function_cfg  = REG_WR & hit_function_cfg;
	wire wr_delay         = REG_WR & hit_delay;
	wire wr_src_ref       = REG_WR & hit_src_ref;

	// ---------------- register writes ----------------
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			first_alarm_polarity_reg  <= `RST_POLARITY;
			second_alarm_polarity_reg <= `RST_POLARITY;
		end else if (wr_polarity) begin
			first_alarm_polarity_reg  <= REG_WDATA[`BIT_FIRST_POLARITY];
			second_alarm_polarity_reg <= REG_WDATA[`BIT_SECOND_POLARITY];
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			low_battery_delay_select_reg <= `RST_DELAY;
		end else if (wr_delay) begin
			low_battery_delay_select_reg <= REG_WDATA[`DELAY_MSB:`DELAY_LSB];
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			first_reference_select_reg  <= `RST_REF;
			first_source_select_reg     <= `RST_SRC;
			second_reference_select_reg <= `RST_REF;
			second_source_select_reg    <= `RST_SRC;
		end else if (wr_src_ref) begin
			first_reference_select_reg  <= REG_WDATA[`BIT_FIRST_REF];
			first_source_select_reg     <= REG_WDATA[`FIRST_SRC_MSB:`FIRST_SRC_LSB];
			second_reference_select_reg <= REG_WDATA[`BIT_SECOND_REF];
			second_source_select_reg    <= REG_WDATA[`SECOND_SRC_MSB:`SECOND_SRC_LSB];
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			data_irq_output_config_reg <= `RST_PIN_CFG;
			pen_irq_output_config_reg  <= `RST_PIN_CFG;
		end else if (wr_output_cfg) begin
			data_irq_output_config_reg <= REG_WDATA[`BIT_DATA_IRQ_CFG];
			pen_irq_output_config_reg  <= REG_WDATA[`BIT_PEN_IRQ_CFG];
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			data_irq_function_config_reg <= `RST_PIN_CFG;
			pen_irq_function_config_reg  <= `RST_PIN_CFG;
		end else if (wr_function_cfg) begin
			data_irq_function_config_reg <= REG_WDATA[`BIT_DATA_IRQ_CFG];
			pen_irq_function_config_reg  <= REG_WDATA[`BIT_PEN_IRQ_CFG];
		end
	end

	// ---------------- register reads ----------------
	// bits outside this block's fields read zero
	reg_word_t rd_output_cfg;
	reg_word_t rd_polarity;
	reg_word_t rd_function_cfg;
	reg_word_t rd_delay;
	reg_word_t rd_src_ref;
	reg_word_t rd_mux;

	always_comb begin
		rd_output_cfg                          = '0;
		rd_output_cfg[`BIT_DATA_IRQ_CFG]       = data_irq_output_config_reg;
		rd_output_cfg[`BIT_PEN_IRQ_CFG]        = pen_irq_output_config_reg;
		rd_function_cfg                        = '0;
		rd_function_cfg[`BIT_DATA_IRQ_CFG]     = data_irq_function_config_reg;
		rd_function_cfg[`BIT_PEN_IRQ_CFG]      = pen_irq_function_config_reg;
		rd_polarity                            = '0;
		rd_polarity[`BIT_FIRST_POLARITY]       = first_alarm_polarity_reg;
		rd_polarity[`BIT_SECOND_POLARITY]      = second_alarm_polarity_reg;
		rd_delay                               = '0;
		rd_delay[`DELAY_MSB:`DELAY_LSB]        = low_battery_delay_select_reg;
		rd_src_ref                             = '0;
		rd_src_ref[`BIT_FIRST_REF]             = first_reference_select_reg;
		rd_src_ref[`FIRST_SRC_MSB:`FIRST_SRC_LSB]   = first_source_select_reg;
		rd_src_ref[`BIT_SECOND_REF]            = second_reference_select_reg;
		rd_src_ref[`SECOND_SRC_MSB:`SECOND_SRC_LSB] = second_source_select_reg;
	end

	assign rd_mux = hit_output_cfg   ? rd_output_cfg   :
	                hit_polarity     ? rd_polarity     :
	                hit_function_cfg ? rd_function_cfg :
	                hit_delay        ? rd_delay        :
	                hit_src_ref      ? rd_src_ref      : '0;

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			REG_RDATA  <= '0;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) begin
				REG_RDATA <= rd_mux;
			end
		end
	end

	// ---------------- comparators ----------------
	logic first_powered;
	logic first_alarm;
	logic second_powered;
	logic second_alarm;

	comparator_channel u_dead_battery (
		.polarity      (first_alarm_polarity_reg),
		.ref_select    (first_reference_select_reg),
		.source_select (first_source_select_reg),
		.raw_above     (DEAD_BATTERY_COMPARATOR),
		.powered       (first_powered),
		.alarm         (first_alarm)
	);

	comparator_channel u_low_battery (
		.polarity      (second_alarm_polarity_reg),
		.ref_select    (second_reference_select_reg),
		.source_select (second_source_select_reg),
		.raw_above     (LOW_BATTERY_COMPARATOR),
		.powered       (second_powered),
		.alarm         (second_alarm)
	);

	// ---------------- frame timebase ----------------
	logic frame_tick;

	frame_tick_divider #(
		.CYCLES (FRAME_CYCLES)
	) u_frame_tick (
		.clk  (CLK),
		.nrst (NRST),
		.tick (frame_tick)
	);

	// ---------------- low battery delay ----------------
	delay_state_t           dly_state_reg;
	delay_state_t           dly_state_next;
	logic [DELAY_CNT_W-1:0] frame_count_reg;
	logic [DELAY_CNT_W-1:0] frame_count_next;
	logic                   qualified_reg;
	logic                   qualified_next;

	wire delay_enabled = (low_battery_delay_select_reg != 3'h0);
	// frames to wait: 2^(base + code); the divider runs free so the first
	// frame may be short by up to one frame period
	wire [DELAY_CNT_W-1:0] delay_target =
		DELAY_CNT_W'(1) << (DELAY_EXP_BASE + int'(low_battery_delay_select_reg));
	wire delay_last_frame = frame_tick & (frame_count_reg == delay_target - DELAY_CNT_W'(1));

	always_comb begin
		dly_state_next   = dly_state_reg;
		frame_count_next = frame_count_reg;
		qualified_next   = qualified_reg;
		// the qualified level drops with the alarm, so a new trigger re-arms
		if (!second_alarm) begin
			qualified_next = 1'b0;
		end
		unique case (dly_state_reg)
			DLY_IDLE: begin
				// status stays untouched while counting
				if (delay_enabled && second_alarm && !qualified_reg) begin
					dly_state_next   = DLY_COUNTING;
					frame_count_next = '0;
				end
			end
			DLY_COUNTING: begin
				// further triggers are not looked at until the recheck
				if (!delay_enabled) begin
					dly_state_next = DLY_IDLE;
				end else if (delay_last_frame) begin
					dly_state_next = DLY_IDLE;
					// inactive here leaves nothing behind
					qualified_next = second_alarm;
				end else if (frame_tick) begin
					frame_count_next = frame_count_reg + DELAY_CNT_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			dly_state_reg   <= DLY_IDLE;
			frame_count_reg <= '0;
			qualified_reg   <= 1'b0;
		end else begin
			dly_state_reg   <= dly_state_next;
			frame_count_reg <= frame_count_next;
			qualified_reg   <= qualified_next;
		end
	end

	// with no delay the status follows the alarm directly
	wire low_status_next = delay_enabled ? qualified_reg : second_alarm;

	// ---------------- outputs ----------------
	wire data_irq_enabled =
		~data_irq_output_config_reg & ~data_irq_function_config_reg;
	wire pen_irq_enabled =
		~pen_irq_output_config_reg & ~pen_irq_function_config_reg;

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			DEAD_BATTERY_STATUS    <= 1'b0;
			LOW_BATTERY_STATUS_BIT <= 1'b0;
			LOW_BATTERY_IRQ        <= 1'b0;
			DELAY_TIMER_BUSY       <= 1'b0;
			OSC_START              <= 1'b0;
			DATA_READY_IRQ_PIN     <= 1'b0;
			TOUCH_DETECT_IRQ_PIN   <= 1'b0;
		end else begin
			DEAD_BATTERY_STATUS    <= first_alarm;
			LOW_BATTERY_STATUS_BIT <= low_status_next;
			LOW_BATTERY_IRQ        <= low_status_next & LOW_BATTERY_IRQ_ENABLE;
			DELAY_TIMER_BUSY       <= (dly_state_next == DLY_COUNTING);
			// oscillator kept running in sleep for the whole count
			OSC_START              <= SLEEP & (dly_state_next == DLY_COUNTING);
			DATA_READY_IRQ_PIN     <= data_irq_enabled & AUX_DATA_READY;
			TOUCH_DETECT_IRQ_PIN   <= pen_irq_enabled & PANEL_TOUCHED;
		end
	end

	assign FIRST_REFERENCE_SELECT  = first_reference_select_reg;
	assign FIRST_SOURCE_SELECT     = first_source_select_reg;
	assign FIRST_POWER_DOWN        = ~first_powered;
	assign SECOND_REFERENCE_SELECT = second_reference_select_reg;
	assign SECOND_SOURCE_SELECT    = second_source_select_reg;
	assign SECOND_POWER_DOWN       = ~second_powered;
endmodule : battery_alarm_irq_control

//--- sim/host_irq_model.sv
// host side of the dedicated pins: counts each interrupt it sees
`timescale 1ns/1ps
module host_irq_model (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic data_pin,
	input  wire logic touch_pin,
	output int        data_events,
	output int        touch_events
);
	logic data_last_reg;
	logic touch_last_reg;
	// edge counting, so a pin stuck high is seen as one event only
	always_ff @(posedge clk) begin
		data_last_reg <= data_pin;
		touch_last_reg <= touch_pin;
		if (!nrst) begin
			data_events <= 0;
			touch_events <= 0;
		end else begin
			data_events <= data_events + int'(data_pin & !data_last_reg);
			touch_events <= touch_events + int'(touch_pin & !touch_last_reg);
		end
	end
endmodule : host_irq_model

//--- sim/battery_alarm_irq_control_monitor.sv
// port checker for the battery alarm control block
`timescale 1ns/1ps
module battery_alarm_irq_control_monitor
	import battery_alarm_pkg::*;
#(
	parameter int FRAME_CYCLES   = 208,
	parameter int DELAY_EXP_BASE = 12
) (
	input wire logic        CLK,
	input wire logic        NRST,
	input wire logic        SLEEP,
	input wire logic        LOW_BATTERY_IRQ_ENABLE,
	input wire logic        AUX_DATA_READY,
	input wire logic        PANEL_TOUCHED,
	input wire logic        FIRST_REFERENCE_SELECT,
	input wire source_sel_t FIRST_SOURCE_SELECT,
	input wire logic        FIRST_POWER_DOWN,
	input wire logic        SECOND_REFERENCE_SELECT,
	input wire source_sel_t SECOND_SOURCE_SELECT,
	input wire logic        SECOND_POWER_DOWN,
	input wire logic        LOW_BATTERY_STATUS_BIT,
	input wire logic        LOW_BATTERY_IRQ,
	input wire logic        DELAY_TIMER_BUSY,
	input wire logic        OSC_START,
	input wire logic        DATA_READY_IRQ_PIN,
	input wire logic        TOUCH_DETECT_IRQ_PIN
);
	// longest code plus slack for the partial first frame
	localparam int BUSY_MAX = FRAME_CYCLES * (2 ** (DELAY_EXP_BASE + 7)) + 4;
	int busy_cnt_reg;
	always_ff @(posedge CLK) begin
		if (!NRST || !DELAY_TIMER_BUSY)
			busy_cnt_reg <= 0;
		else
			busy_cnt_reg <= busy_cnt_reg + 1;
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	property p_first_off;
		FIRST_POWER_DOWN == (FIRST_SOURCE_SELECT == 2'h0 && !FIRST_REFERENCE_SELECT);
	endproperty
	property p_second_off;
		SECOND_POWER_DOWN == (SECOND_SOURCE_SELECT == 2'h0 && !SECOND_REFERENCE_SELECT);
	endproperty
	property p_data_pin;
		DATA_READY_IRQ_PIN |-> $past(AUX_DATA_READY);
	endproperty
	property p_touch_pin;
		TOUCH_DETECT_IRQ_PIN |-> $past(PANEL_TOUCHED);
	endproperty
	property p_irq_gate;
		LOW_BATTERY_IRQ |-> $past(LOW_BATTERY_IRQ_ENABLE);
	endproperty
	property p_osc;
		OSC_START |-> $past(SLEEP);
	endproperty
	property p_hold;
		$rose(DELAY_TIMER_BUSY) |-> $stable(LOW_BATTERY_STATUS_BIT) [*2];
	endproperty
	property p_busy_len;
		busy_cnt_reg <= BUSY_MAX;
	endproperty
	a_first_off: assert property (p_first_off)
		else $error("first power-down decode wrong");
	a_second_off: assert property (p_second_off)
		else $error("second power-down decode wrong");
	a_data_pin: assert property (p_data_pin)
		else $error("data pin high without ready input");
	a_touch_pin: assert property (p_touch_pin)
		else $error("touch pin high without touch input");
	a_irq_gate: assert property (p_irq_gate)
		else $error("low battery irq without enable");
	a_osc: assert property (p_osc)
		else $error("oscillator start outside sleep");
	a_hold: assert property (p_hold)
		else $error("status moved as delay timer started");
	a_busy_len: assert property (p_busy_len)
		else $error("delay timer ran too long");
	c_busy: cover property ($rose(DELAY_TIMER_BUSY));
	c_status: cover property ($rose(LOW_BATTERY_STATUS_BIT));
	c_osc: cover property (OSC_START);
endmodule : battery_alarm_irq_control_monitor
bind battery_alarm_irq_control battery_alarm_irq_control_monitor #(
	.FRAME_CYCLES(FRAME_CYCLES), .DELAY_EXP_BASE(DELAY_EXP_BASE)
) battery_alarm_irq_control_monitor_inst (
	.CLK(CLK), .NRST(NRST), .SLEEP(SLEEP), .LOW_BATTERY_IRQ_ENABLE(LOW_BATTERY_IRQ_ENABLE),
	.AUX_DATA_READY(AUX_DATA_READY), .PANEL_TOUCHED(PANEL_TOUCHED),
	.FIRST_REFERENCE_SELECT(FIRST_REFERENCE_SELECT), .FIRST_SOURCE_SELECT(FIRST_SOURCE_SELECT),
	.FIRST_POWER_DOWN(FIRST_POWER_DOWN), .SECOND_REFERENCE_SELECT(SECOND_REFERENCE_SELECT),
	.SECOND_SOURCE_SELECT(SECOND_SOURCE_SELECT), .SECOND_POWER_DOWN(SECOND_POWER_DOWN),
	.LOW_BATTERY_STATUS_BIT(LOW_BATTERY_STATUS_BIT), .LOW_BATTERY_IRQ(LOW_BATTERY_IRQ),
	.DELAY_TIMER_BUSY(DELAY_TIMER_BUSY), .OSC_START(OSC_START),
	.DATA_READY_IRQ_PIN(DATA_READY_IRQ_PIN), .TOUCH_DETECT_IRQ_PIN(TOUCH_DETECT_IRQ_PIN)
);

//--- sim/battery_alarm_irq_control_tb_top.sv
// self-checking bench for the battery alarm control block
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("BAD %s expected %0h seen %0h", what, exp, got); end end
module battery_alarm_irq_control_tb_top
	import battery_alarm_pkg::*;
;
	localparam int FC = 4;
	localparam logic [6:0] OFS [5] = '{7'h4C, 7'h4E, 7'h56, 7'h58, 7'h5C};
	localparam reg_word_t RST_V [5] = '{16'h0018, 16'hC000, 16'h0018, 16'h0000, 16'h0000};
	localparam reg_word_t MSK_V [5] = '{16'h0018, 16'hC000, 16'h0018, 16'hE000, 16'h7E00};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [6:0] addr = 7'h00;
	reg_word_t wdata = 16'h0000;
	logic c1 = 1'b0, c2 = 1'b0, sleep = 1'b0, irq_en = 1'b0, aux_rdy = 1'b0, touched = 1'b0;
	reg_word_t rdata;
	source_sel_t src1, src2;
	logic rvalid, ref1, pd1, ref2, pd2, dead_st, low_st, low_irq, busy, osc, data_pin, touch_pin;
	int data_events, touch_events;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	battery_alarm_irq_control #(.FRAME_CYCLES(FC), .DELAY_EXP_BASE(0))
	battery_alarm_irq_control_inst (
		.CLK(clk), .NRST(nrst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .REG_RVALID(rvalid), .DEAD_BATTERY_COMPARATOR(c1),
		.LOW_BATTERY_COMPARATOR(c2), .SLEEP(sleep), .LOW_BATTERY_IRQ_ENABLE(irq_en),
		.AUX_DATA_READY(aux_rdy), .PANEL_TOUCHED(touched), .FIRST_REFERENCE_SELECT(ref1),
		.FIRST_SOURCE_SELECT(src1), .FIRST_POWER_DOWN(pd1), .SECOND_REFERENCE_SELECT(ref2),
		.SECOND_SOURCE_SELECT(src2), .SECOND_POWER_DOWN(pd2), .DEAD_BATTERY_STATUS(dead_st),
		.LOW_BATTERY_STATUS_BIT(low_st), .LOW_BATTERY_IRQ(low_irq), .DELAY_TIMER_BUSY(busy),
		.OSC_START(osc), .DATA_READY_IRQ_PIN(data_pin), .TOUCH_DETECT_IRQ_PIN(touch_pin)
	);
	host_irq_model host_irq_model_inst (
		.clk(clk), .nrst(nrst), .data_pin(data_pin), .touch_pin(touch_pin),
		.data_events(data_events), .touch_events(touch_events)
	);
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr_reg(input logic [6:0] a, input reg_word_t d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [6:0] a, input reg_word_t e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK("rvalid", 1'b1, rvalid)
		`CHK("rdata", e, rdata)
	endtask : rd_chk
	task automatic t_regs();
		for (int i = 0; i < 5; i++) rd_chk(OFS[i], RST_V[i]);
		for (int i = 0; i < 5; i++) begin
			wr_reg(OFS[i], 16'hFFFF);
			rd_chk(OFS[i], MSK_V[i]);
		end
		wr_reg(7'h50, 16'hFFFF);
		rd_chk(7'h50, 16'h0000);
		$display("test regs done");
	endtask : t_regs
	task automatic t_source();
		for (int i = 0; i < 8; i++) begin
			wr_reg(7'h5C, {1'b0, i[2:0], i[2:0], 9'h000});
			#1;
			`CHK("pd1", 1'(i == 0), pd1)
			`CHK("pd2", 1'(i == 0), pd2)
			`CHK("ref1", i[2], ref1)
			`CHK("ref2", i[2], ref2)
			`CHK("src1", i[1:0], src1)
			`CHK("src2", i[1:0], src2)
		end
		$display("test source done");
	endtask : t_source
	task automatic t_pins();
		@(posedge clk);
		aux_rdy <= 1'b1;
		touched <= 1'b1;
		tick(3);
		`CHK("data pin off", 1'b0, data_pin)
		`CHK("touch pin off", 1'b0, touch_pin)
		// output config cleared first, then function config; the pins stay off until both are zero
		wr_reg(7'h4C, 16'h0000);
		wr_reg(7'h56, 16'h0000);
		tick(2);
		`CHK("data pin on", 1'b1, data_pin)
		`CHK("touch pin on", 1'b1, touch_pin)
		@(posedge clk);
		touched <= 1'b0;
		tick(2);
		`CHK("touch released", 1'b0, touch_pin)
		@(posedge clk);
		aux_rdy <= 1'b0;
		touched <= 1'b1;
		tick(2);
		`CHK("data done", 1'b0, data_pin)
		`CHK("touch again", 1'b1, touch_pin)
		`CHK("data events", 1, data_events)
		`CHK("touch events", 2, touch_events)
		wr_reg(7'h4C, 16'h0018);
		wr_reg(7'h56, 16'h0018);
		tick(2);
		`CHK("touch disabled", 1'b0, touch_pin)
		touched <= 1'b0;
		$display("test pins done");
	endtask : t_pins
	task automatic t_direct();
		wr_reg(7'h58, 16'h0000);
		wr_reg(7'h5C, 16'h1200);
		for (int i = 0; i < 4; i++) begin
			wr_reg(7'h4E, {i[1], i[1], 14'h0000});
			c1 <= i[0];
			c2 <= i[0];
			irq_en <= i[0];
			tick(3);
			`CHK("dead status", 1'(i[1] == i[0]), dead_st)
			`CHK("low status", 1'(i[1] == i[0]), low_st)
			`CHK("low irq", 1'(i[1] == i[0] && i[0]), low_irq)
		end
		@(posedge clk);
		c1 <= 1'b0;
		c2 <= 1'b0;
		tick(3);
		$display("test direct done");
	endtask : t_direct
	task automatic t_delay();
		int n;
		int lo;
		int hi;
		for (int code = 1; code < 8; code++) begin
			wr_reg(7'h58, {code[2:0], 13'h0000});
			sleep <= code[0];
			irq_en <= code[1];
			@(posedge clk);
			c2 <= 1'b1;
			tick(3);
			`CHK("busy", 1'b1, busy)
			`CHK("held status", 1'b0, low_st)
			`CHK("osc", code[0], osc)
			@(posedge clk);
			c2 <= 1'b0;
			if (code[0]) begin
				@(posedge clk);
				c2 <= 1'b1;
			end
			n = 3;
			while (busy === 1'b1 && n < 700) begin
				@(posedge clk);
				#1;
				n++;
			end
			lo = FC * ((2 ** code) - 1);
			hi = FC * (2 ** code) + 3;
			`CHK("delay span", 1'b1, 1'(n >= lo && n <= hi))
			tick(1);
			`CHK("status", code[0], low_st)
			`CHK("irq", 1'(code[0] && code[1]), low_irq)
			`CHK("osc off", 1'b0, osc)
			@(posedge clk);
			c2 <= 1'b0;
			tick(3);
		end
		// clearing the delay code mid-count must abort the timer
		wr_reg(7'h58, 16'h2000);
		@(posedge clk);
		c2 <= 1'b1;
		tick(3);
		`CHK("abort busy", 1'b1, busy)
		wr_reg(7'h58, 16'h0000);
		tick(1);
		`CHK("abort idle", 1'b0, busy)
		`CHK("abort status", 1'b1, low_st)
		@(posedge clk);
		c2 <= 1'b0;
		tick(3);
		$display("test delay done");
	endtask : t_delay
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs();
		t_source();
		t_pins();
		t_direct();
		t_delay();
		tally_and_finish();
	end
endmodule : battery_alarm_irq_control_tb_top
